//--- icmo_pkg.sv
// Constants shared by the instruction-cache maintenance block.
// Assumes big-endian bit numbering in the instruction set is mapped to
// little-endian vectors here: instruction bit 0 is vector bit 31.

package icmo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  localparam logic [5:0] OPC_PRIMARY = 6'h1f;     // Primary opcode 31
  localparam logic [9:0] XO_INVAL_LINE = 10'h3d6; // Extended opcode 982
  localparam logic [9:0] XO_TOUCH = 10'h106;      // Extended opcode 262
  localparam logic [9:0] XO_FLASH = 10'h3c6;      // Extended opcode 966
  localparam logic [9:0] XO_READ = 10'h3e6;       // Extended opcode 998
  localparam int OPC_HI = 31;                     // Instruction bits 0:5
  localparam int OPC_LO = 26;
  localparam int BASE_FIELD_HI = 20;              // Instruction bits 11:15
  localparam int BASE_FIELD_LO = 16;
  localparam int XO_HI = 10;                      // Instruction bits 21:30
  localparam int XO_LO = 1;
  localparam logic [4:0] BASE_FIELD_ZERO = 5'h00; // Field value meaning base 0

  ////////////////////////////////////////////////////////////////////////////
  // Effective-address fields
  localparam int SET_W = 8;                       // Bits 19:26 pick the class
  localparam int SET_LO = 5;
  localparam int WORD_W = 3;                      // Bits 27:29 pick the word
  localparam int WORD_LO = 2;
  localparam int TAG_W = 19;                      // Bits 0:18 form the tag
  localparam int TAG_LO = 13;
  localparam logic [4:0] LINE_OFFSET_ZERO = 5'h00; // Aligns a 32-byte line
  localparam logic [2:0] LAST_BEAT = 3'h7;        // Eight words per line

  ////////////////////////////////////////////////////////////////////////////
  // Debug data register layout and reset value
  localparam int TAG_OR_WORD_FIELD_HI = 31;                    // Bits 0:21
  localparam int TAG_OR_WORD_FIELD_LO = 10;
  localparam int VALID_POS = 4;                   // Bit 27
  localparam int LRU_POS = 0;                     // Bit 31
  localparam logic [2:0] TAG_PAD = 3'h0;          // Tag is left-aligned in tag_or_word_field
  localparam logic [31:0] DEBUG_DATA_RESET = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Operation and sequencer states
  typedef enum logic [2:0] {
    ICMO_OP_NONE,
    ICMO_OP_INVAL,
    ICMO_OP_TOUCH,
    ICMO_OP_FLASH,
    ICMO_OP_READ
  } icmo_op_e;

  typedef enum logic [1:0] {
    ICMO_IDLE,
    ICMO_EXEC,
    ICMO_FILL
  } icmo_state_e;

endpackage : icmo_pkg

//--- icmo_store.sv
// Two-way tag, data, valid and LRU storage of the instruction cache.
// Assumes one set index per cycle from the sequencer; reads are combinational.
`timescale 1ns/10ps

module icmo_store #(
  parameter int SET_W = 8,
  parameter int WORD_W = 3,
  parameter int TAG_W = 19
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [SET_W-1:0] set_i,
  input wire logic [TAG_W-1:0] tag_i,
  input wire logic [WORD_W-1:0] word_i,
  input wire logic rd_way_i,
  output logic [1:0] hit_o,
  output logic lru_o,
  output logic rd_valid_o,
  output logic [TAG_W-1:0] rd_tag_o,
  output logic [31:0] rd_data_o,
  input wire logic [1:0] inval_mask_i,
  input wire logic flash_i,
  input wire logic wr_en_i,
  input wire logic wr_way_i,
  input wire logic [WORD_W-1:0] wr_word_i,
  input wire logic [31:0] wr_data_i,
  input wire logic tag_wr_i
);

  localparam int SETS = 1 << SET_W;
  localparam int WORDS = SETS << WORD_W;

  logic [TAG_W-1:0] tag_mem [0:1][0:SETS-1];  // Tags, no reset needed
  logic [31:0] data_mem [0:1][0:WORDS-1];     // Instruction words
  logic [SETS-1:0][1:0] valid_reg;            // Per-way valid bits
  logic [SETS-1:0][1:0] valid_next;
  logic [SETS-1:0] lru_reg;                   // 1 means way B is oldest
  logic [SETS-1:0] lru_next;

  ////////////////////////////////////////////////////////////////////////////
  // Valid and LRU next state; flash clear wins over any line update
  always_comb
  begin
    valid_next = valid_reg;
    lru_next = lru_reg;
    if (flash_i)
    begin
      valid_next = '0;
    end
    else
    begin
      valid_next[set_i] = valid_reg[set_i] & ~inval_mask_i;
      if (tag_wr_i)
      begin
        valid_next[set_i][wr_way_i] = 1'b1;
        lru_next[set_i] = ~wr_way_i;
      end
    end
  end

  // Valid and LRU bits reset so the cache starts empty
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      valid_reg <= '0;
      lru_reg <= '0;
    end
    else
    begin
      valid_reg <= valid_next;
      lru_reg <= lru_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array writes; arrays are not reset since valid bits guard them
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      data_mem[wr_way_i][{set_i, wr_word_i}] <= wr_data_i;
    end
    if (tag_wr_i)
    begin
      tag_mem[wr_way_i][set_i] <= tag_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-way hit compare
  for (genvar w = 0; w < 2; w++)
  begin : g_way
    assign hit_o[w] = valid_reg[set_i][w] && (tag_mem[w][set_i] == tag_i);
  end

  // Debug read port
  assign lru_o = lru_reg[set_i];
  assign rd_valid_o = valid_reg[set_i][rd_way_i];
  assign rd_tag_o = tag_mem[rd_way_i][set_i];
  assign rd_data_o = data_mem[rd_way_i][{set_i, word_i}];

endmodule : icmo_store

//--- icmo_top.sv
// Instruction-cache maintenance sequencer: line invalidate, line touch,
// whole-cache invalidate and debug read into the debug data register.
// Assumes the execute stage presents operands, privilege and translation
// results with op_valid_i, all on clk_i, and holds nothing after acceptance.
`timescale 1ns/10ps

module icmo_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] base_value_i,
  input wire logic [31:0] index_value_i,
  input wire logic user_mode_i,
  input wire logic data_reloc_i,
  input wire logic tlb_hit_i,
  input wire logic zone_no_access_i,
  input wire logic cachable_i,
  input wire logic way_select_bit_i,
  input wire logic tag_or_word_field_select_bit_i,
  input wire logic sync_req_i,
  input wire logic fill_valid_i,
  input wire logic [31:0] fill_data_i,
  output logic busy_o,
  output logic done_o,
  output logic exc_data_storage_o,
  output logic exc_dtlb_miss_o,
  output logic exc_program_o,
  output logic dac_check_o,
  output logic dac_is_load_o,
  output logic [31:0] dac_addr_o,
  output logic [31:0] icache_debug_data_o,
  output logic fill_req_o,
  output logic [31:0] fill_addr_o,
  output logic sync_done_o,
  output logic flush_fetch_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State and output registers
  icmo_pkg::icmo_state_e state_reg, state_next;   // Sequencer state
  icmo_pkg::icmo_op_e op_reg, op_next;            // Operation in flight
  logic [31:0] ea_reg, ea_next;                   // Captured effective address
  logic cach_reg, cach_next;                      // Storage attribute at issue
  logic way_reg, way_next;                        // Way select at issue
  logic tag_or_word_field_reg, tag_or_word_field_next;                      // Tag_or_word_field select at issue
  logic victim_reg, victim_next;                  // Way chosen for a fill
  logic [2:0] beat_reg, beat_next;                // Fill word counter
  logic sync_pend_reg, sync_pend_next;            // Sync waiting to finish
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic dsi_reg, dsi_next;
  logic dtlb_reg, dtlb_next;
  logic prog_reg, prog_next;
  logic dac_reg, dac_next;
  logic [31:0] dac_addr_reg, dac_addr_next;
  logic [31:0] debug_reg, debug_next;             // Debug data register
  logic fill_req_reg, fill_req_next;
  logic [31:0] fill_addr_reg, fill_addr_next;
  logic sync_done_reg, sync_done_next;
  logic flush_reg, flush_next;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the presented instruction
  logic [5:0] opc;                                // Primary opcode
  logic [9:0] xo;                                 // Extended opcode
  logic [4:0] base_reg_field;                     // Base register number
  logic [31:0] base_eff;                          // Base after zero rule
  logic [31:0] ea_calc;                           // Effective address
  icmo_pkg::icmo_op_e op_dec;
  logic tlb_fault;                                // Relocation without entry
  logic zone_fault;                               // User no-access zone

  assign opc = instr_i[icmo_pkg::OPC_HI:icmo_pkg::OPC_LO];
  assign xo = instr_i[icmo_pkg::XO_HI:icmo_pkg::XO_LO];
  assign base_reg_field = instr_i[icmo_pkg::BASE_FIELD_HI:icmo_pkg::BASE_FIELD_LO];
  // Base field of zero means a literal zero base, not register zero
  assign base_eff = (base_reg_field == icmo_pkg::BASE_FIELD_ZERO) ? 32'h00000000 : base_value_i;
  assign ea_calc = base_eff + index_value_i;
  assign tlb_fault = data_reloc_i && !tlb_hit_i;
  assign zone_fault = user_mode_i && data_reloc_i && zone_no_access_i;

  // Bits 6:10 and bit 31 are never looked at, so a non-zero reserved bit
  // simply runs the decoded operation: bounded, and no program fault
  always_comb
  begin
    op_dec = icmo_pkg::ICMO_OP_NONE;
    if (opc == icmo_pkg::OPC_PRIMARY)
    begin
      case (xo)
        icmo_pkg::XO_INVAL_LINE: op_dec = icmo_pkg::ICMO_OP_INVAL;
        icmo_pkg::XO_TOUCH: op_dec = icmo_pkg::ICMO_OP_TOUCH;
        icmo_pkg::XO_FLASH: op_dec = icmo_pkg::ICMO_OP_FLASH;
        icmo_pkg::XO_READ: op_dec = icmo_pkg::ICMO_OP_READ;
        default: op_dec = icmo_pkg::ICMO_OP_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cache storage, addressed by the captured effective address
  logic [1:0] hit;
  logic lru;
  logic rd_valid;
  logic [icmo_pkg::TAG_W-1:0] rd_tag;
  logic [31:0] rd_data;
  logic [1:0] inval_mask;
  logic flash;
  logic wr_en;
  logic tag_wr;
  logic [21:0] tag_or_word_field;                 // Tag_or_word_field loaded on debug read

  icmo_store #(
    .SET_W(icmo_pkg::SET_W),
    .WORD_W(icmo_pkg::WORD_W),
    .TAG_W(icmo_pkg::TAG_W)
  ) u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(ea_reg[icmo_pkg::SET_LO +: icmo_pkg::SET_W]),
    .tag_i(ea_reg[icmo_pkg::TAG_LO +: icmo_pkg::TAG_W]),
    .word_i(ea_reg[icmo_pkg::WORD_LO +: icmo_pkg::WORD_W]),
    .rd_way_i(way_reg),
    .hit_o(hit),
    .lru_o(lru),
    .rd_valid_o(rd_valid),
    .rd_tag_o(rd_tag),
    .rd_data_o(rd_data),
    .inval_mask_i(inval_mask),
    .flash_i(flash),
    .wr_en_i(wr_en),
    .wr_way_i(victim_reg),
    .wr_word_i(beat_reg),
    .wr_data_i(fill_data_i),
    .tag_wr_i(tag_wr)
  );

  // Word mode keeps the upper 22 bits of the word; tag mode left-aligns it
  assign tag_or_word_field = tag_or_word_field_reg ? {rd_tag, icmo_pkg::TAG_PAD} : rd_data[31:10];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    ea_next = ea_reg;
    cach_next = cach_reg;
    way_next = way_reg;
    tag_or_word_field_next = tag_or_word_field_reg;
    victim_next = victim_reg;
    beat_next = beat_reg;
    sync_pend_next = sync_pend_reg | sync_req_i;
    debug_next = debug_reg;
    fill_req_next = fill_req_reg;
    fill_addr_next = fill_addr_reg;
    dac_addr_next = dac_addr_reg;
    // Pulses default low
    done_next = 1'b0;
    dsi_next = 1'b0;
    dtlb_next = 1'b0;
    prog_next = 1'b0;
    dac_next = 1'b0;
    sync_done_next = 1'b0;
    flush_next = 1'b0;
    inval_mask = 2'h0;
    flash = 1'b0;
    wr_en = 1'b0;
    tag_wr = 1'b0;
    case (state_reg)
      icmo_pkg::ICMO_IDLE:
      begin
        // A pending sync holds off every later operation
        if (op_valid_i && !sync_pend_reg)
        begin
          op_next = op_dec;
          ea_next = ea_calc;
          cach_next = cachable_i;
          way_next = way_select_bit_i;
          tag_or_word_field_next = tag_or_word_field_select_bit_i;
          state_next = icmo_pkg::ICMO_EXEC;
          case (op_dec)
            icmo_pkg::ICMO_OP_INVAL:
            begin
              // Compare unit sees this as a load
              dac_next = 1'b1;
              dac_addr_next = ea_calc;
              // Faults go out as data-side faults only
              if (tlb_fault)
              begin
                dtlb_next = 1'b1;
              end
              else if (zone_fault)
              begin
                dsi_next = 1'b1;
              end
            end
            icmo_pkg::ICMO_OP_TOUCH:
            begin
              dac_next = 1'b1;
              dac_addr_next = ea_calc;
              // A would-be fault turns the touch into a quiet no-op
              if (tlb_fault || zone_fault)
              begin
                op_next = icmo_pkg::ICMO_OP_NONE;
              end
            end
            icmo_pkg::ICMO_OP_FLASH:
            begin
              // Only privilege is checked; no data or compare faults
              prog_next = user_mode_i;
            end
            icmo_pkg::ICMO_OP_READ:
            begin
              if (user_mode_i)
              begin
                prog_next = 1'b1;
              end
              else if (tlb_fault)
              begin
                dtlb_next = 1'b1;
              end
            end
            default:
            begin
              op_next = icmo_pkg::ICMO_OP_NONE;
            end
          endcase
          // Faulted operations end at once with no cache effect
          if (dsi_next || dtlb_next || prog_next)
          begin
            done_next = 1'b1;
            state_next = icmo_pkg::ICMO_IDLE;
          end
        end
        else if (sync_pend_reg)
        begin
          // Idle means every earlier operation has finished
          sync_done_next = 1'b1;
          flush_next = 1'b1;
          sync_pend_next = sync_req_i;
        end
      end
      icmo_pkg::ICMO_EXEC:
      begin
        done_next = 1'b1;
        state_next = icmo_pkg::ICMO_IDLE;
        case (op_reg)
          icmo_pkg::ICMO_OP_INVAL:
          begin
            // Cachability is not consulted; a miss changes nothing
            inval_mask = hit;
          end
          icmo_pkg::ICMO_OP_FLASH:
          begin
            flash = 1'b1;
          end
          icmo_pkg::ICMO_OP_READ:
          begin
            // Reserved bits are forced to zero
            debug_next = icmo_pkg::DEBUG_DATA_RESET;
            debug_next[icmo_pkg::TAG_OR_WORD_FIELD_HI:icmo_pkg::TAG_OR_WORD_FIELD_LO] = tag_or_word_field;
            debug_next[icmo_pkg::VALID_POS] = rd_valid;
            debug_next[icmo_pkg::LRU_POS] = lru;
          end
          icmo_pkg::ICMO_OP_TOUCH:
          begin
            // Only an absent cachable line is fetched
            if (cach_reg && (hit == 2'h0))
            begin
              done_next = 1'b0;
              state_next = icmo_pkg::ICMO_FILL;
              victim_next = lru;
              beat_next = 3'h0;
              fill_req_next = 1'b1;
              fill_addr_next = {ea_reg[31:5], icmo_pkg::LINE_OFFSET_ZERO};
            end
          end
          default:
          begin
            done_next = 1'b1;
          end
        endcase
      end
      icmo_pkg::ICMO_FILL:
      begin
        // Words arrive in order; tag and valid are set with the last one
        if (fill_valid_i)
        begin
          wr_en = 1'b1;
          beat_next = beat_reg + 3'h1;
          if (beat_reg == icmo_pkg::LAST_BEAT)
          begin
            tag_wr = 1'b1;
            fill_req_next = 1'b0;
            done_next = 1'b1;
            beat_next = 3'h0;
            state_next = icmo_pkg::ICMO_IDLE;
          end
        end
      end
      default:
      begin
        state_next = icmo_pkg::ICMO_IDLE;
      end
    endcase
    busy_next = (state_next != icmo_pkg::ICMO_IDLE) || sync_pend_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; the debug register updates with done, and a register read
  // issued earlier than a sync may still see the old value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= icmo_pkg::ICMO_IDLE;
      op_reg <= icmo_pkg::ICMO_OP_NONE;
      ea_reg <= 32'h00000000;
      cach_reg <= 1'b0;
      way_reg <= 1'b0;
      tag_or_word_field_reg <= 1'b0;
      victim_reg <= 1'b0;
      beat_reg <= 3'h0;
      sync_pend_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      dsi_reg <= 1'b0;
      dtlb_reg <= 1'b0;
      prog_reg <= 1'b0;
      dac_reg <= 1'b0;
      dac_addr_reg <= 32'h00000000;
      debug_reg <= icmo_pkg::DEBUG_DATA_RESET;
      fill_req_reg <= 1'b0;
      fill_addr_reg <= 32'h00000000;
      sync_done_reg <= 1'b0;
      flush_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      ea_reg <= ea_next;
      cach_reg <= cach_next;
      way_reg <= way_next;
      tag_or_word_field_reg <= tag_or_word_field_next;
      victim_reg <= victim_next;
      beat_reg <= beat_next;
      sync_pend_reg <= sync_pend_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      dsi_reg <= dsi_next;
      dtlb_reg <= dtlb_next;
      prog_reg <= prog_next;
      dac_reg <= dac_next;
      dac_addr_reg <= dac_addr_next;
      debug_reg <= debug_next;
      fill_req_reg <= fill_req_next;
      fill_addr_reg <= fill_addr_next;
      sync_done_reg <= sync_done_next;
      flush_reg <= flush_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign exc_data_storage_o = dsi_reg;
  assign exc_dtlb_miss_o = dtlb_reg;
  assign exc_program_o = prog_reg;
  assign dac_check_o = dac_reg;
  assign dac_is_load_o = dac_reg;
  assign dac_addr_o = dac_addr_reg;
  assign icache_debug_data_o = debug_reg;
  assign fill_req_o = fill_req_reg;
  assign fill_addr_o = fill_addr_reg;
  assign sync_done_o = sync_done_reg;
  assign flush_fetch_o = flush_reg;

endmodule : icmo_top

//--- icmo_fill_model.sv
// Main-memory model answering line fills of the instruction cache.
// Assumes fill_req_i and fill_addr_i hold steady through a fill.
`timescale 1ns/10ps
module icmo_fill_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fill_req_i,
  input wire logic [31:0] fill_addr_i,
  input wire logic slow_i,
  output logic valid_o,
  output logic [31:0] data_o
);
  logic [3:0] beat; // Words taken so far
  logic gap; // Slow mode idles every other cycle
  ////////////////////////////////////////////////////////////////////////////
  // Eight words in line order, then silence until the next request
  always @(posedge clk_i)
  begin
    if (rst_i || !fill_req_i)
    begin
      beat <= 4'h0;
      valid_o <= 1'b0;
      gap <= 1'b0;
    end
    else
    begin
      beat <= beat + {3'h0, valid_o};
      gap <= slow_i && !gap;
      valid_o <= (beat + {3'h0, valid_o} < 4'h8) && !(slow_i && !gap);
    end
  end
  // Word names its beat and line; idle cycles show the inverse, never a stale word
  assign data_o = {5'h00, beat[2:0], fill_addr_i[23:0]} ^ {32{!valid_o}};
endmodule : icmo_fill_model

//--- icmo_properties.sv
// Timing checks on the ports of the cache maintenance sequencer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module icmo_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] base_value_i,
  input wire logic [31:0] index_value_i,
  input wire logic user_mode_i,
  input wire logic data_reloc_i,
  input wire logic tlb_hit_i,
  input wire logic sync_req_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic exc_data_storage_o,
  input wire logic exc_dtlb_miss_o,
  input wire logic exc_program_o,
  input wire logic dac_check_o,
  input wire logic dac_is_load_o,
  input wire logic [31:0] dac_addr_o,
  input wire logic [31:0] icache_debug_data_o,
  input wire logic fill_req_o,
  input wire logic [31:0] fill_addr_o,
  input wire logic sync_done_o,
  input wire logic flush_fetch_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] ea; // Address the request names
  assign ea = (instr_i[20:16] == icmo_pkg::BASE_FIELD_ZERO ? 32'h0 : base_value_i) + index_value_i;
  // An accepted request of one kind
  sequence s_take(logic [9:0] code);
    op_valid_i && !busy_o && instr_i[31:26] == icmo_pkg::OPC_PRIMARY && instr_i[10:1] == code;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_exc_with_done: assert property ((exc_data_storage_o || exc_dtlb_miss_o || exc_program_o) |-> done_o)
    else $error("exception without done");
  a_dac_as_load: assert property (dac_check_o |-> dac_is_load_o && $past(op_valid_i))
    else $error("compare check not a load");
  a_flash_user: assert property (s_take(icmo_pkg::XO_FLASH) ##0 user_mode_i |=> done_o && exc_program_o
    && !dac_check_o && !exc_data_storage_o && !exc_dtlb_miss_o) else $error("user flash not refused");
  a_flash_quiet: assert property (s_take(icmo_pkg::XO_FLASH) ##0 !user_mode_i |=>
    (!dac_check_o && !exc_data_storage_o && !exc_dtlb_miss_o)[*2]) else $error("flash raised data fault");
  a_inval_tlb: assert property (s_take(icmo_pkg::XO_INVAL_LINE) ##0 data_reloc_i && !tlb_hit_i |=>
    done_o && exc_dtlb_miss_o && dac_check_o && dac_addr_o == $past(ea)) else $error("invalidate miss fault");
  a_touch_quiet: assert property (s_take(icmo_pkg::XO_TOUCH) |=> dac_check_o && dac_addr_o == $past(ea)
    ##0 (!exc_data_storage_o && !exc_dtlb_miss_o)[*2]) else $error("touch fault or address");
  a_read_user: assert property (s_take(icmo_pkg::XO_READ) ##0 user_mode_i |=> done_o && exc_program_o)
    else $error("user read not refused");
  a_sync_flush: assert property (sync_req_i && !busy_o && !op_valid_i |-> ##[1:4] sync_done_o && flush_fetch_o)
    else $error("sync not completed");
  a_fill_aligned: assert property (fill_req_o |-> fill_addr_o[4:0] == icmo_pkg::LINE_OFFSET_ZERO)
    else $error("fill address not line aligned");
  a_dbg_holds: assert property (!done_o && !$past(rst_i) |-> $stable(icache_debug_data_o))
    else $error("debug data changed without done");
endmodule : icmo_properties

bind icmo_top icmo_properties chk (.clk_i, .rst_i, .op_valid_i, .instr_i, .base_value_i, .index_value_i,
  .user_mode_i, .data_reloc_i, .tlb_hit_i, .sync_req_i, .busy_o, .done_o, .exc_data_storage_o, .exc_dtlb_miss_o,
  .exc_program_o, .dac_check_o, .dac_is_load_o, .dac_addr_o, .icache_debug_data_o, .fill_req_o, .fill_addr_o,
  .sync_done_o, .flush_fetch_o);

//--- tb_top.sv
// Self-checking bench for the cache maintenance sequencer.
// Assumes the fill model stands on the line-fill link.
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0, user_mode_i = 1'b0, data_reloc_i = 1'b0;
  logic tlb_hit_i = 1'b0, zone_no_access_i = 1'b0, cachable_i = 1'b0, sync_req_i = 1'b0, slow = 1'b0;
  logic way_select_bit_i = 1'b0, tag_or_word_field_select_bit_i = 1'b0, fill_valid_i, fill_req_o, sync_done_o;
  logic busy_o, done_o, exc_data_storage_o, exc_dtlb_miss_o, exc_program_o, dac_check_o, dac_is_load_o;
  logic flush_fetch_o;
  logic [31:0] instr_i = 32'h0, base_value_i = 32'h0, index_value_i = 32'h0, fill_data_i;
  logic [31:0] dac_addr_o, icache_debug_data_o, fill_addr_o, ex;
  logic [31:0] fills = 32'h0; // Words taken on the fill link
  logic [4:0] rsv = 5'h00; // Reserved instruction bits
  int num_errors = 0;
  int n_checks = 0;
  icmo_top dut (.clk_i, .rst_i, .op_valid_i, .instr_i, .base_value_i, .index_value_i, .user_mode_i,
    .data_reloc_i, .tlb_hit_i, .zone_no_access_i, .cachable_i, .way_select_bit_i, .tag_or_word_field_select_bit_i,
    .sync_req_i, .fill_valid_i, .fill_data_i, .busy_o, .done_o, .exc_data_storage_o, .exc_dtlb_miss_o,
    .exc_program_o, .dac_check_o, .dac_is_load_o, .dac_addr_o, .icache_debug_data_o, .fill_req_o,
    .fill_addr_o, .sync_done_o, .flush_fetch_o);
  icmo_fill_model mem (.clk_i, .rst_i, .fill_req_i(fill_req_o), .fill_addr_i(fill_addr_o), .slow_i(slow),
    .valid_o(fill_valid_i), .data_o(fill_data_i));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (fill_req_o && fill_valid_i)
      fills <= fills + 32'h1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // Bounded wait for done, or for sync completion when sel is set
  task automatic settle(input logic sel);
    int n = 0;
    #1;
    while ((sel ? sync_done_o : done_o) !== 1'b1 && n < 60)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 60)
    begin
      num_errors++;
      end_of_test();
    end
  endtask : settle
  // One request for one cycle; m is way, tag_or_word_field, cachable, user, reloc, tlb hit, zone
  task automatic op(input logic [9:0] xo, input logic [4:0] ra, input logic [31:0] b, input logic [31:0] x,
    input logic [6:0] m);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    instr_i <= {icmo_pkg::OPC_PRIMARY, rsv, ra, 5'h07, xo, 1'b0};
    base_value_i <= b;
    index_value_i <= x;
    {way_select_bit_i, tag_or_word_field_select_bit_i, cachable_i, user_mode_i, data_reloc_i, tlb_hit_i, zone_no_access_i} <= m;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    settle(1'b0);
    ex = {29'h0, exc_program_o, exc_data_storage_o, exc_dtlb_miss_o};
  endtask : op
  task automatic t_sync;
    @(posedge clk_i);
    sync_req_i <= 1'b1;
    @(posedge clk_i);
    sync_req_i <= 1'b0;
    settle(1'b1);
    chk("flush", {31'h0, flush_fetch_o}, 32'h1);
  endtask : t_sync
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_flash;
    rsv = 5'h15;
    op(icmo_pkg::XO_FLASH, 5'h00, 32'h0, 32'h0, 7'b0001100);
    chk("flash_user", ex, 32'h4);
    op(icmo_pkg::XO_FLASH, 5'h04, 32'h0, 32'h0, 7'b0000101);
    chk("flash_priv", ex, 32'h0);
    rsv = 5'h00;
  endtask : t_flash
  // Slow fill to way A, fast fill to way B, then hit, uncachable and faulting touches
  task automatic t_touch;
    slow = 1'b1;
    op(icmo_pkg::XO_TOUCH, 5'h03, 32'h1000_0000, 32'h0000_0120, 7'b0010110);
    chk("fill_addr", fill_addr_o, 32'h1000_0120);
    chk("fills", fills, 32'h8);
    slow = 1'b0;
    op(icmo_pkg::XO_TOUCH, 5'h00, 32'hffff_ffff, 32'h2000_0120, 7'b0010010);
    op(icmo_pkg::XO_TOUCH, 5'h00, 32'h0, 32'h2000_0124, 7'b0010010);
    op(icmo_pkg::XO_TOUCH, 5'h00, 32'h0, 32'h3000_0000, 7'b0000010);
    op(icmo_pkg::XO_TOUCH, 5'h00, 32'h0, 32'h4000_0000, 7'b0011101);
    chk("touch_exc", ex, 32'h0);
    chk("fills", fills, 32'h10);
  endtask : t_touch
  task automatic t_read;
    op(icmo_pkg::XO_READ, 5'h00, 32'hffff_ffff, 32'h1000_012c, 7'b0000010);
    t_sync();
    chk("word_a", icache_debug_data_o, 32'h0300_0010);
    op(icmo_pkg::XO_READ, 5'h00, 32'h0, 32'h2000_0120, 7'b1100010);
    chk("tag_b", icache_debug_data_o, 32'h2000_0010);
    op(icmo_pkg::XO_READ, 5'h00, 32'h0, 32'h2000_0120, 7'b1101010);
    chk("read_user", ex, 32'h4);
    op(icmo_pkg::XO_READ, 5'h00, 32'h0, 32'h2000_0120, 7'b0000100);
    chk("read_tlb", ex, 32'h1);
  endtask : t_read
  // Faulted invalidates leave the line; a clean one clears it even uncachable
  task automatic t_inval;
    op(icmo_pkg::XO_INVAL_LINE, 5'h05, 32'h1000_0000, 32'h0000_0120, 7'b0000100);
    chk("inval_tlb", ex, 32'h1);
    chk("dac_addr", dac_addr_o, 32'h1000_0120);
    op(icmo_pkg::XO_INVAL_LINE, 5'h00, 32'h0, 32'h1000_0120, 7'b0001111);
    chk("inval_zone", ex, 32'h2);
    op(icmo_pkg::XO_INVAL_LINE, 5'h00, 32'h0, 32'h1000_0124, 7'b0000000);
    op(icmo_pkg::XO_READ, 5'h00, 32'h0, 32'h1000_0120, 7'b0100010);
    chk("tag_a", icache_debug_data_o, 32'h1000_0000);
    op(icmo_pkg::XO_FLASH, 5'h00, 32'h0, 32'h0, 7'b0000010);
    op(icmo_pkg::XO_READ, 5'h00, 32'h0, 32'h2000_0120, 7'b1100010);
    chk("tag_b", icache_debug_data_o, 32'h2000_0000);
  endtask : t_inval
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_flash();
    t_touch();
    t_read();
    t_inval();
    end_of_test();
  end
endmodule : tb_top
